// ===== design/swl_fifo.sv
// file: small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module swl_fifo
  import swl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // full and empty come straight from the count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== design/swl_phy.sv
// file: single-wire slave physical and rom command layer
`timescale 1ns/1ns
// Operation
// R1 - every slot starts at master falling edge
// R2 - drive line only by open-drain pulldown
// R3 - standard and fast speeds supported
// R4 - long low taken as reset
// R5 - master order: reset, rom, function, data
// R6 - reset answered with presence pulse
// R7 - only presence falling edge from slave
// R8 - standard speed unless switched fast
// R9 - reset 480us or more clears fast speed
// R10 - short fast-speed reset keeps fast speed
// R11 - master lengthens reset by fall time
// R12 - presence after delay, held for low time
// R13 - master samples presence at sample time
// R14 - ready for data after reset window
// R15 - master may stretch reset high window
// R16 - one bit per time slot
// R17 - falling edge starts internal slot timer
// R18 - master meets write low times
// R19 - recovery before next slot
// R20 - read zero holds line low until timer
// R21 - master samples read inside window
// R22 - eight-bit rom commands in write slots
// R23 - 33h returns 64-bit identity
// R24 - 55h matches identity or waits reset
// R25 - 3Ch skips and sets fast speed
// R26 - CCh grants function access without identity
// R27 - bits move least significant first
module swl_phy
  import swl_pkg::*;
#(
  parameter logic [63:0] DEV_ID = ID_DEFAULT,
  parameter int RST_STD = RESET_LOW_STD_CYC,
  parameter int RST_OD = RESET_LOW_OD_CYC,
  parameter int RST_KEEP = RST_OD_KEEP_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic fast_speed_flag,
  output logic selected,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_mode
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_LOW = 6'b00_0010,
    ST_PDH = 6'b00_0100,
    ST_PDL = 6'b00_1000,
    ST_HIGH = 6'b01_0000,
    ST_WAITRST = 6'b10_0000
  } swl_state_t;
  typedef enum logic [4:0] {
    PH_CMD = 5'b0_0001,
    PH_READID = 5'b0_0010,
    PH_MATCH = 5'b0_0100,
    PH_FUNC = 5'b0_1000,
    PH_NONE = 5'b1_0000
  } swl_phase_t;

  swl_state_t st_r;
  swl_phase_t ph_r;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [TMR_W-1:0] tmr_r;
  logic od_r;
  logic slot_od_r;
  logic pull_r;
  logic sampled_r;
  logic [6:0] bit_r;
  logic [7:0] sh_r;
  logic rd_bit_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic tx_have_r;
  logic rx_push_r;
  logic [7:0] rx_byte_r;
  logic fifo_ready;

  // two-flop input synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      sync1_r <= line_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // speed-dependent counts and line decode
  wire fall = prev_r && !sync2_r; // see R1
  wire rise = !prev_r && sync2_r;
  // only a fall seen while the slave is not driving opens a slot
  wire idle_st = (st_r == ST_IDLE) || (st_r == ST_HIGH) ||
                 (st_r == ST_WAITRST);
  wire slot_fall = fall && idle_st; // see R1 R7
  // slot timing follows the speed at slot start, so a speed change
  // mid-slot cannot turn a long write-zero into a reset
  wire [TMR_W-1:0] samp_cyc = slot_od_r ? TMR_W'(SAMP_OD_CYC) :
                              TMR_W'(SAMP_STD_CYC); // see R3
  wire [TMR_W-1:0] pdh_cyc = od_r ? TMR_W'(PDH_OD_CYC) : TMR_W'(PDH_STD_CYC);
  wire [TMR_W-1:0] pdl_cyc = od_r ? TMR_W'(PDL_OD_CYC) : TMR_W'(PDL_STD_CYC);
  wire [TMR_W-1:0] rst_cyc = slot_od_r ? TMR_W'(RST_OD) :
                             TMR_W'(RST_STD); // see R4
  wire is_reset = (tmr_r >= rst_cyc);
  wire long_reset = (tmr_r >= TMR_W'(RST_STD));
  wire keep_reset = (tmr_r <= TMR_W'(RST_KEEP));
  wire reading = (ph_r == PH_READID) || (ph_r == PH_FUNC && tx_mode);
  wire sample_pt = (st_r == ST_LOW) && (tmr_r == samp_cyc) && !sampled_r;
  wire wr_bit = sync2_r;
  wire [7:0] cmd_byte = {wr_bit, sh_r[7:1]}; // see R27
  wire byte_done = (bit_r[2:0] == 3'd7);
  // last bit of a rom command sampled this cycle
  wire cmd_end = sample_pt && (ph_r == PH_CMD) && byte_done;

  // open-drain: output is always low, only the enable moves
  assign line_out = 1'b0; // see R2
  assign line_oe = pull_r; // see R2
  assign fast_speed_flag = od_r;
  assign selected = (ph_r == PH_FUNC);
  assign tx_ready = !tx_have_r;

  // bit timer restarted at slot start and at the end of a reset low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_r <= '0;
    end else if (slot_fall || (st_r == ST_LOW && rise && is_reset)) begin
      tmr_r <= '0; // see R17
    end else if (tmr_r != '1) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // line state machine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      od_r <= 1'b0; // see R8
      slot_od_r <= 1'b0;
      pull_r <= 1'b0;
      sampled_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE, ST_HIGH, ST_WAITRST: begin
          pull_r <= 1'b0;
          if (slot_fall) begin
            st_r <= ST_LOW; // see R1
            sampled_r <= 1'b0;
            slot_od_r <= od_r; // see R8
          end
        end
        ST_LOW: begin
          if (sample_pt) begin
            sampled_r <= 1'b1;
          end
          // read zero: hold low until sample point
          if (tmr_r == '0 && ph_r != PH_NONE && reading && !rd_bit_r) begin
            pull_r <= 1'b1; // see R20
          end else if (tmr_r >= samp_cyc) begin
            pull_r <= 1'b0; // see R20
          end
          // an early rise (write one, read one) waits for the sample point
          if (rise && is_reset) begin
            if (long_reset) od_r <= 1'b0; // see R9
            else if (!keep_reset) od_r <= 1'b0; // see R10
            st_r <= ST_PDH; // see R6
          end else if (sync2_r && (sampled_r || sample_pt)) begin
            st_r <= ST_HIGH; // see R19
          end
        end
        ST_PDH: begin
          if (tmr_r >= pdh_cyc) begin
            st_r <= ST_PDL; // see R12
            pull_r <= 1'b1; // see R7
          end
        end
        ST_PDL: begin
          if (tmr_r >= pdh_cyc + pdl_cyc) begin
            pull_r <= 1'b0; // see R12
            st_r <= ST_HIGH; // see R14
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      if (cmd_end && cmd_byte == CMD_FAST_SKIP) begin
        od_r <= 1'b1; // see R25
      end
    end
  end

  // rom command and data framing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= PH_NONE;
      bit_r <= '0;
      sh_r <= '0;
      rx_push_r <= 1'b0;
      rx_byte_r <= '0;
    end else begin
      rx_push_r <= 1'b0;
      if (st_r == ST_PDL) begin
        ph_r <= PH_CMD; // see R6
        bit_r <= '0;
      end else if (sample_pt) begin
        bit_r <= bit_r + 1'b1; // see R16
        case (ph_r)
          PH_CMD: begin
            sh_r <= cmd_byte; // see R22
            if (byte_done) begin
              bit_r <= '0;
              if (cmd_byte == CMD_READ_ID) ph_r <= PH_READID; // see R23
              else if (cmd_byte == CMD_MATCH_ID) ph_r <= PH_MATCH;
              else if (cmd_byte == CMD_SKIP_ID) ph_r <= PH_FUNC; // see R26
              else if (cmd_byte == CMD_FAST_SKIP) ph_r <= PH_FUNC; // see R25
              else ph_r <= PH_NONE;
            end
          end
          PH_READID: begin
            if (bit_r == 7'd63) ph_r <= PH_NONE; // see R23
          end
          PH_MATCH: begin
            if (wr_bit != DEV_ID[bit_r[5:0]]) ph_r <= PH_NONE; // see R24
            else if (bit_r == 7'd63) begin
              ph_r <= PH_FUNC; // see R24
              bit_r <= '0;
            end
          end
          PH_FUNC: begin
            if (!tx_mode) begin
              sh_r <= cmd_byte; // see R27
              if (byte_done) begin
                rx_byte_r <= cmd_byte;
                rx_push_r <= fifo_ready;
              end
            end
          end
          default: begin
            ph_r <= PH_NONE;
          end
        endcase
      end
    end
  end

  // next read bit: identity or queued transmit byte, lsb first
  always_comb begin
    if (ph_r == PH_READID) rd_bit_r = DEV_ID[bit_r[5:0]]; // see R27
    else rd_bit_r = tx_have_r ? tx_sh_r[0] : 1'b1;
  end

  // transmit byte holder for function-phase reads
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      tx_have_r <= 1'b0;
    end else if (tx_valid && !tx_have_r) begin
      tx_sh_r <= tx_data;
      tx_cnt_r <= '0;
      tx_have_r <= 1'b1;
    end else if (sample_pt && ph_r == PH_FUNC && tx_mode && tx_have_r) begin
      tx_sh_r <= {1'b1, tx_sh_r[7:1]};
      tx_cnt_r <= tx_cnt_r + 1'b1;
      if (tx_cnt_r == 3'd7) tx_have_r <= 1'b0;
    end
  end

  // received function bytes queue toward the user
  swl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(rx_push_r),
    .in_ready(fifo_ready),
    .in_data(rx_byte_r),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // checks
  sequence presence_seq;
    (st_r == ST_PDH) ##1 (st_r == ST_PDL);
  endsequence
  pres_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R12
    presence_seq |-> ##1 line_oe) else $error("presence not driven");
  od_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R2
    line_out == 1'b0) else $error("line driven high");
  slot_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R1
    (st_r == ST_IDLE && !fall) |=> st_r != ST_LOW) else $error("slot unprompted");
  long_rst_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R9
    (st_r == ST_LOW && rise && long_reset) |=> !od_r) else $error("fast kept");
  std_default_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R8
    $rose(od_r) |-> $past(ph_r) == PH_CMD) else $error("fast without command");
  timer_clr_a: assert property ( // see R17
    @(posedge sys_clk) disable iff (!arst_n)
    slot_fall |=> tmr_r == '0) else $error("timer not restarted");
  rd_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R20
    (st_r == ST_LOW && tmr_r > samp_cyc + 1) |-> !line_oe) else $error("hold long");
  match_fail_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R24
    (sample_pt && ph_r == PH_MATCH && wr_bit != DEV_ID[bit_r[5:0]])
    |=> ph_r == PH_NONE) else $error("mismatch kept");
  // reset, presence and slot checks
  sequence rst_rise_seq;
    st_r == ST_LOW && rise && is_reset;
  endsequence
  sequence pres_end_seq;
    st_r == ST_PDL && tmr_r >= pdh_cyc + pdl_cyc;
  endsequence
  rst_timer_a: assert property ( // see R12
    @(posedge sys_clk) disable iff (!arst_n)
    rst_rise_seq |=> st_r == ST_PDH && tmr_r == '0)
    else $error("presence delay not restarted");
  pres_end_a: assert property ( // see R14
    @(posedge sys_clk) disable iff (!arst_n)
    pres_end_seq |=> st_r == ST_HIGH && !line_oe)
    else $error("presence not ended");
  keep_fast_a: assert property ( // see R10
    @(posedge sys_clk) disable iff (!arst_n)
    rst_rise_seq ##0 (slot_od_r && keep_reset && !long_reset) |=> od_r)
    else $error("short reset left fast speed");
  rise_high_a: assert property ( // see R19
    @(posedge sys_clk) disable iff (!arst_n)
    st_r == ST_LOW && rise && !is_reset && sampled_r |=> st_r == ST_HIGH)
    else $error("slot not closed");
  one_sample_a: assert property ( // see R16
    @(posedge sys_clk) disable iff (!arst_n)
    sample_pt |=> sampled_r && !sample_pt)
    else $error("slot sampled twice");
  // command decode checks
  fast_set_a: assert property ( // see R25
    @(posedge sys_clk) disable iff (!arst_n)
    cmd_end && cmd_byte == CMD_FAST_SKIP |=> od_r && selected)
    else $error("fast skip not applied");
  read_id_a: assert property ( // see R23
    @(posedge sys_clk) disable iff (!arst_n)
    cmd_end && cmd_byte == CMD_READ_ID |=> ph_r == PH_READID)
    else $error("identity read not entered");
  skip_grant_a: assert property ( // see R26
    @(posedge sys_clk) disable iff (!arst_n)
    cmd_end && cmd_byte == CMD_SKIP_ID |=> selected)
    else $error("skip not granted");
endmodule

// ===== design/swl_pkg.sv
// package: timing and command constants for the single-wire slave
package swl_pkg;
  localparam int CLK_MHZ = 25;
  // reset detection thresholds in microseconds
  localparam int RST_STD_US = 480;
  localparam int RST_OD_US = 48;
  localparam int RST_OD_KEEP_US = 80;
  localparam int RESET_LOW_STD_CYC = RST_STD_US * CLK_MHZ;
  localparam int RESET_LOW_OD_CYC = RST_OD_US * CLK_MHZ;
  localparam int RST_OD_KEEP_CYC = RST_OD_KEEP_US * CLK_MHZ;
  // presence delay and low time, standard and fast speed
  localparam int PDH_STD_US = 30;
  localparam int PDL_STD_US = 120;
  localparam int PDH_OD_US = 3;
  localparam int PDL_OD_US = 12;
  localparam int PDH_STD_CYC = PDH_STD_US * CLK_MHZ;
  localparam int PDL_STD_CYC = PDL_STD_US * CLK_MHZ;
  localparam int PDH_OD_CYC = PDH_OD_US * CLK_MHZ;
  localparam int PDL_OD_CYC = PDL_OD_US * CLK_MHZ;
  // write sample point and read-zero hold, standard and fast speed
  localparam int SAMP_STD_US = 30;
  localparam int SAMP_OD_US = 5;
  localparam int SAMP_STD_CYC = SAMP_STD_US * CLK_MHZ;
  localparam int SAMP_OD_CYC = SAMP_OD_US * CLK_MHZ;
  localparam int TMR_W = 14;
  // rom function commands
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID = 8'h55;
  localparam logic [7:0] CMD_FAST_SKIP = 8'h3c;
  localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
  // identity value, arbitrary
  localparam logic [63:0] ID_DEFAULT = 64'h5a00_1234_5678_9a01;
endpackage

// ===== testbench/swl_master.sv
// bus master model for the single-wire slave, open-drain pulldown only
`timescale 1ns/1ns
module swl_master (
  input wire logic sys_clk,
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0;
  // pull the line low for n cycles, changes only at falling edges
  task automatic low_for(input int n);
    @(negedge sys_clk);
    pull = 1'b1;
    repeat (n) @(negedge sys_clk);
    pull = 1'b0;
  endtask
  // reset pulse, then one sample before and one inside presence
  task automatic reset(input int low, input int pdh, input int pdl,
                       output logic early, output logic pres);
    low_for(low);
    repeat (pdh / 2) @(negedge sys_clk);
    early = line;
    repeat (pdh / 2 + pdl / 2) @(negedge sys_clk);
    pres = line;
    repeat (pdl / 2 + pdl / 4) @(negedge sys_clk);
  endtask
  // one write slot with recovery up to full slot length
  task automatic write_bit(input logic b, input logic fast);
    int low;
    int slot;
    low = b ? 25 : (fast ? 150 : 1000);
    slot = fast ? 400 : 2150;
    low_for(low);
    repeat (slot - low) @(negedge sys_clk);
  endtask
  // one read slot, sampled before the slave timer ends
  task automatic read_bit(input logic fast, output logic b);
    low_for(25);
    repeat (fast ? 75 : 475) @(negedge sys_clk);
    b = line;
    repeat (fast ? 300 : 1650) @(negedge sys_clk);
  endtask
  // one byte, low bit first
  task automatic write_byte(input logic [7:0] v, input logic fast);
    for (int i = 0; i < 8; i++) begin
      write_bit(v[i], fast);
    end
  endtask
endmodule

// ===== testbench/swl_phy_test.sv
// self-checking bench for the single-wire slave phy
`timescale 1ns/1ns
module swl_phy_test;
  import swl_pkg::*;
  localparam int R_STD = 2500;
  localparam int R_OD = 400;
  localparam int R_KEEP = 600;
  localparam int F_DEPTH = 4;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_mode = 1'b0;
  logic m_pull;
  logic line_out;
  logic line_oe;
  logic fast_speed_flag;
  logic selected;
  logic rx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic e;
  logic p;
  logic b;
  logic [63:0] v;
  wire bus_line;
  int errors = 0;
  int num_checks = 0;
  // wired-and line with pull-up
  assign bus_line = (m_pull | line_oe) ? 1'b0 : 1'b1;
  // clock
  always #20 sys_clk = ~sys_clk;
  swl_phy #(.RST_STD(R_STD), .RST_OD(R_OD), .RST_KEEP(R_KEEP),
            .FIFO_DEPTH(F_DEPTH)) swl_phy_i (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .line_in(bus_line),
    .line_out(line_out),
    .line_oe(line_oe),
    .fast_speed_flag(fast_speed_flag),
    .selected(selected),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_mode(tx_mode)
  );
  swl_master swl_master_i (
    .sys_clk(sys_clk),
    .line(bus_line),
    .pull(m_pull)
  );
  // compare and report
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // pulldown only while enabled
  always @(posedge sys_clk) begin
    if (line_oe === 1'b1) check(line_out, 1'b0);
  end
  // reset pulse and presence at the given speed
  task automatic do_reset(input int low, input logic fast);
    swl_master_i.reset(low, fast ? PDH_OD_CYC : PDH_STD_CYC,
                       fast ? PDL_OD_CYC : PDL_STD_CYC, e, p);
    check(e, 1'b1);
    check(p, 1'b0);
  endtask
  // standard reset, then fast skip command
  task automatic t_go_fast();
    check(line_oe, 1'b0);
    check(tx_ready, 1'b1);
    do_reset(R_STD + 50, 1'b0);
    check(fast_speed_flag, 1'b0);
    swl_master_i.write_byte(CMD_FAST_SKIP, 1'b0);
    check(fast_speed_flag, 1'b1);
    check(selected, 1'b1);
  endtask
  // fill the fifo past full with reader stalled, then drain
  task automatic t_fifo();
    for (int i = 0; i < F_DEPTH + 1; i++) begin
      swl_master_i.write_byte(8'h10 + 8'(i), 1'b1);
    end
    @(negedge sys_clk);
    rx_ready = 1'b1;
    for (int i = 0; i < F_DEPTH; i++) begin
      check(rx_valid, 1'b1);
      check(rx_data, 8'h10 + 8'(i));
      @(negedge sys_clk);
    end
    check(rx_valid, 1'b0);
  endtask
  // hand a byte to the phy and read it back in read slots
  task automatic t_tx_read();
    @(negedge sys_clk);
    check(tx_ready, 1'b1);
    tx_data = 8'ha5;
    tx_valid = 1'b1;
    @(negedge sys_clk);
    tx_valid = 1'b0;
    check(tx_ready, 1'b0);
    tx_mode = 1'b1;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      swl_master_i.read_bit(1'b1, b);
      v[i] = b;
    end
    check(v, 64'h0000_0000_0000_00a5);
    tx_mode = 1'b0;
  endtask
  // short reset in fast speed keeps fast speed
  task automatic t_keep_fast();
    do_reset(R_OD + 50, 1'b1);
    check(fast_speed_flag, 1'b1);
    check(selected, 1'b0);
  endtask
  // read identity, low bit first
  task automatic t_read_id();
    swl_master_i.write_byte(CMD_READ_ID, 1'b1);
    for (int i = 0; i < 64; i++) begin
      swl_master_i.read_bit(1'b1, b);
      v[i] = b;
    end
    check(v, ID_DEFAULT);
  endtask
  // wrong identity after match drops out; skip then grants access
  task automatic t_match_skip();
    do_reset(R_OD + 50, 1'b1);
    swl_master_i.write_byte(CMD_MATCH_ID, 1'b1);
    swl_master_i.write_bit(~ID_DEFAULT[0], 1'b1);
    check(selected, 1'b0);
    do_reset(R_OD + 50, 1'b1);
    swl_master_i.write_byte(CMD_SKIP_ID, 1'b1);
    check(selected, 1'b1);
    check(fast_speed_flag, 1'b1);
  endtask
  // long reset returns to standard speed
  task automatic t_long_reset();
    do_reset(R_STD + 50, 1'b0);
    check(fast_speed_flag, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_go_fast();
    t_fifo();
    t_tx_read();
    t_keep_fast();
    t_read_id();
    t_match_skip();
    t_long_reset();
    close_out();
  end
  // watchdog, a little beyond the full sequence
  initial begin
    #3_800_000;
    errors++;
    close_out();
  end
endmodule
